/* File: hdl/pirq_top.v */
// Purpose: PCI-side interrupt enable, status, routing and VME interrupt handling
// Assumes: event inputs are one-cycle pulses on i_clk_sys; VME lines are raw pins
// Notes: enable register doubles as the mask of the summary interrupt
`timescale 1ns/100ps
`default_nettype none
`include "pirq_regs.vh"

module pirq_top #(
	parameter VEC_W = 8
) (
	input wire i_clk_sys,
	input wire i_nrst,
	// Wishbone slave
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [11:0] i_wb_adr,
	input wire [3:0] i_wb_sel,
	input wire [31:0] i_wb_dat,
	output reg [31:0] o_wb_dat,
	output reg o_wb_ack,
	// Event pulses from bridge logic
	input wire [3:0] i_loc_watch,
	input wire [3:0] i_msgbox,
	input wire i_soft_vme_ack_irq,
	input wire i_vme_err_irq,
	input wire i_pci_err_irq,
	input wire i_dma_irq,
	input wire i_vme_own_irq,
	// VME pins, active low
	input wire i_acfail_n,
	input wire i_sysfail_n,
	input wire [7:1] i_vme_irq_level_line_n,
	// VME master for acknowledge cycles
	input wire i_vme_bus_grant,
	input wire i_iack_done,
	input wire i_iack_berr,
	input wire [VEC_W-1:0] i_iack_vector,
	output wire o_vme_bus_req,
	output wire o_iack_req,
	output wire [2:0] o_iack_level,
	// Interrupt outputs
	output reg [7:0] o_pci_irq_out,
	output reg o_irq
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Byte enables to a 32-bit lane mask
	function [31:0] lane_mask;
		input [3:0] sel;
		begin
			lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		end
	endfunction

	// Three-bit route field of source b: nibble b of the packed maps
	function [2:0] route_of;
		input [4:0] b;
		input [95:0] maps;
		begin
			route_of = maps[{b, 2'b00} +: 3];
		end
	endfunction

	// Word offset match; the two low address bits never select a register
	function adr_hit;
		input [11:0] adr;
		input [11:0] off;
		begin
			adr_hit = (adr[11:2] == off[11:2]);
		end
	endfunction

	// Byte-lane merge of write data into a held word
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] wdat;
		input [31:0] mask;
		begin
			lane_merge = (old & ~mask) | (wdat & mask);
		end
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	reg [31:0] en_q;
	reg [31:0] stat_q;
	reg [31:0] stat_d;
	reg [31:0] map0_q;
	reg [31:0] map1_q;
	reg [31:0] map2_q;
	reg [VEC_W-1:0] vec_q [1:7];
	reg [8:0] pin_s1_q;
	reg [8:0] pin_s2_q;
	reg [31:0] set_v;
	reg [31:0] clr_v;
	reg [31:0] rd_v;
	reg [7:0] irq_out_d;
	reg [7:1] cap_lvl_v;
	wire req_v;
	wire wr_v;
	wire [31:0] wmask;
	wire [31:0] en_new;
	wire [31:0] act;
	wire [95:0] maps;
	wire acfail_lvl;
	wire sysfail_lvl;
	wire [7:1] lvl_line;
	wire [7:1] pend;
	wire cap_valid;
	wire [2:0] cap_level;
	wire [VEC_W-1:0] cap_vector;
	wire [11:0] vec_off;
	wire hit_en;
	wire hit_stat;
	wire hit_map0;
	wire hit_map1;
	wire hit_map2;
	wire hit_vec;
	integer i;
	integer j;
	integer k;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------

	// Two flops per pin; inverted so high means asserted
	// Only the second stage feeds logic; the first may still be settling
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_s1_q <= 9'h000;
			pin_s2_q <= 9'h000;
		end else begin
			pin_s1_q <= ~{i_acfail_n, i_sysfail_n, i_vme_irq_level_line_n};
			pin_s2_q <= pin_s1_q;
		end
	end

	assign acfail_lvl = pin_s2_q[8];
	assign sysfail_lvl = pin_s2_q[7];
	assign lvl_line = pin_s2_q[6:0];

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------

	// Ack one cycle after the request, dropped the cycle after
	assign req_v = i_wb_cyc && i_wb_stb && !o_wb_ack;
	// Writes land on the edge where the master sees ack
	assign wr_v = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
	assign wmask = lane_mask(i_wb_sel);
	assign vec_off = i_wb_adr - `PIRQ_OFF_VEC1;

	// Register selects, shared by read mux, writes and clears
	assign hit_en = adr_hit(i_wb_adr, `PIRQ_OFF_EN);
	assign hit_stat = adr_hit(i_wb_adr, `PIRQ_OFF_STAT);
	assign hit_map0 = adr_hit(i_wb_adr, `PIRQ_OFF_MAP0);
	assign hit_map1 = adr_hit(i_wb_adr, `PIRQ_OFF_MAP1);
	assign hit_map2 = adr_hit(i_wb_adr, `PIRQ_OFF_MAP2);
	// Vector stores fill one contiguous run of words
	assign hit_vec = (i_wb_adr[11:2] >= `PIRQ_OFF_VEC1 >> 2) && (i_wb_adr[11:2] <= `PIRQ_OFF_VEC7 >> 2);

	// Read mux; unmapped offsets read zero but still ack
	// Data is registered at the taking edge, so this path has a full cycle
	always @* begin
		rd_v = `PIRQ_RST_WORD;
		if (hit_en)
			rd_v = en_q;
		else if (hit_stat)
			rd_v = stat_q;
		else if (hit_map0)
			rd_v = map0_q;
		else if (hit_map1)
			rd_v = map1_q;
		else if (hit_map2)
			rd_v = map2_q;
		else if (hit_vec)
			rd_v = {{(32 - VEC_W){1'b0}}, vec_q[vec_off[4:2] + 3'd1]};
	end

	// Ack and read data registers
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= `PIRQ_RST_WORD;
		end else begin
			o_wb_ack <= req_v;
			if (req_v)
				o_wb_dat <= rd_v;
		end
	end

	// ----------------------------------------------------------------
	// Enable and route registers
	// ----------------------------------------------------------------

	// reserved bits 31..24 and 11 never stick
	assign en_new = lane_merge(en_q, i_wb_dat, wmask) & `PIRQ_EN_WMASK;

	// Software-written state; all cleared by reset
	// Route fields of the reserved source are masked so they always read zero
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			en_q <= `PIRQ_RST_WORD;
			map0_q <= `PIRQ_RST_WORD;
			map1_q <= `PIRQ_RST_WORD;
			map2_q <= `PIRQ_RST_WORD;
		end else if (wr_v) begin
			if (hit_en)
				en_q <= en_new;
			else if (hit_map0)
				map0_q <= lane_merge(map0_q, i_wb_dat, wmask) & `PIRQ_MAP_WMASK;
			else if (hit_map1)
				map1_q <= lane_merge(map1_q, i_wb_dat, wmask) & `PIRQ_MAP1_WMASK;
			else if (hit_map2)
				map2_q <= lane_merge(map2_q, i_wb_dat, wmask) & `PIRQ_MAP_WMASK;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt events
	// ----------------------------------------------------------------

	// Level capture decoded to one bit per level
	always @* begin
		cap_lvl_v = 7'h00;
		for (i = 1; i < 8; i = i + 1) begin
			if (cap_valid && cap_level == i[2:0])
				cap_lvl_v[i] = 1'b1;
		end
	end

	// Set terms; each event and fail term gated by its own enable, level terms set by capture alone
	always @* begin
		set_v = `PIRQ_RST_WORD;
		// a cleared enable blocks the source
		set_v[`PIRQ_B_LOCW0 +: 4] = i_loc_watch & en_q[`PIRQ_B_LOCW0 +: 4];
		set_v[`PIRQ_B_MSGBOX_0 +: 4] = i_msgbox & en_q[`PIRQ_B_MSGBOX_0 +: 4];
		set_v[`PIRQ_B_SOFTACK] = i_soft_vme_ack_irq & en_q[`PIRQ_B_SOFTACK];
		set_v[`PIRQ_B_VME_ERR_IRQ] = i_vme_err_irq & en_q[`PIRQ_B_VME_ERR_IRQ];
		set_v[`PIRQ_B_PERR] = i_pci_err_irq & en_q[`PIRQ_B_PERR];
		set_v[`PIRQ_B_DMA] = i_dma_irq & en_q[`PIRQ_B_DMA];
		set_v[`PIRQ_B_VME_OWN_IRQ] = i_vme_own_irq & en_q[`PIRQ_B_VME_OWN_IRQ];
		// fail bits re-set every cycle the pin stays asserted
		set_v[`PIRQ_B_ACFAIL] = acfail_lvl & en_q[`PIRQ_B_ACFAIL];
		set_v[`PIRQ_B_SYSFAIL] = sysfail_lvl & en_q[`PIRQ_B_SYSFAIL];
		// only a 0 to 1 write of the soft enable fires
		set_v[`PIRQ_B_SOFT] = wr_v && hit_en &&
			en_new[`PIRQ_B_SOFT] && !en_q[`PIRQ_B_SOFT];
		// level status set with the captured vector
		set_v[`PIRQ_B_VLVL1 +: 7] = cap_lvl_v;
	end

	// Write-one-to-clear terms from the status offset
	always @* begin
		clr_v = `PIRQ_RST_WORD;
		if (wr_v && hit_stat)
			clr_v = i_wb_dat & wmask;
	end

	// sticky status, a set in the clear cycle wins
	always @* begin
		stat_d = ((stat_q & ~clr_v) | set_v) & `PIRQ_EN_WMASK;
	end

	// the soft status is left alone when its enable drops
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst)
			stat_q <= `PIRQ_RST_WORD;
		else
			stat_q <= stat_d;
	end

	// ----------------------------------------------------------------
	// VME interrupt handler
	// ----------------------------------------------------------------

	// disabled levels never request; a set status holds its level off
	assign pend = lvl_line & en_q[`PIRQ_B_VLVL1 +: 7] & ~stat_q[`PIRQ_B_VLVL1 +: 7];

	pirq_iack #(
		.VEC_W(VEC_W)
	) u_iack (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_pend(pend),
		.i_vme_bus_grant(i_vme_bus_grant),
		.i_iack_done(i_iack_done),
		.i_iack_berr(i_iack_berr),
		.i_iack_vector(i_iack_vector),
		.o_vme_bus_req(o_vme_bus_req),
		.o_iack_req(o_iack_req),
		.o_iack_level(o_iack_level),
		.o_cap_valid(cap_valid),
		.o_cap_level(cap_level),
		.o_cap_vector(cap_vector)
	);

	// per-level vector store, rewritten only by a new capture
	// A bus-error end captures nothing, so the old vector survives it
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			for (k = 1; k < 8; k = k + 1)
				vec_q[k] <= {VEC_W{1'b0}};
		end else if (cap_valid && cap_level != 3'd0) begin
			vec_q[cap_level] <= cap_vector;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt routing
	// ----------------------------------------------------------------

	// a source is live only with status and enable both set
	assign act = stat_q & en_q & `PIRQ_EN_WMASK;
	assign maps = {map2_q, map1_q, map0_q};

	// each live source drives the output its field selects
	// Every source lands on exactly one output, so the summary is their OR
	always @* begin
		irq_out_d = 8'h00;
		for (j = 0; j < `PIRQ_NSRC; j = j + 1) begin
			if (act[j])
				irq_out_d[route_of(j[4:0], maps)] = 1'b1;
		end
	end

	// Registered outputs; one cycle behind status, glitch free
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pci_irq_out <= 8'h00;
			o_irq <= 1'b0;
		end else begin
			o_pci_irq_out <= irq_out_d;
			o_irq <= |act;
		end
	end

endmodule // pirq_top

`default_nettype wire

/* File: hdl/pirq_regs.vh */
// Purpose: register map, field positions and reset values of the PCI-side interrupt block
// Assumes: 32-bit classic Wishbone slave, byte addresses, one aligned word per register
// Notes: status, enable and routing share one bit layout per source
`ifndef PIRQ_REGS_VH
`define PIRQ_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PIRQ_OFF_EN 12'h300
`define PIRQ_OFF_STAT 12'h304
`define PIRQ_OFF_MAP0 12'h308
`define PIRQ_OFF_MAP1 12'h30c
`define PIRQ_OFF_MAP2 12'h310
`define PIRQ_OFF_VEC1 12'h314
`define PIRQ_OFF_VEC7 12'h32c

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define PIRQ_RST_WORD 32'h00000000
`define PIRQ_EN_WMASK 32'h00fff7ff
`define PIRQ_MAP_WMASK 32'h77777777
`define PIRQ_MAP1_WMASK 32'h77770777

// ----------------------------------------------------------------
// Field positions in enable and status
// ----------------------------------------------------------------
`define PIRQ_B_LOCW0 20
`define PIRQ_B_MSGBOX_0 16
`define PIRQ_B_ACFAIL 15
`define PIRQ_B_SYSFAIL 14
`define PIRQ_B_SOFT 13
`define PIRQ_B_SOFTACK 12
`define PIRQ_B_VME_ERR_IRQ 10
`define PIRQ_B_PERR 9
`define PIRQ_B_DMA 8
`define PIRQ_B_VLVL1 1
`define PIRQ_B_VME_OWN_IRQ 0
`define PIRQ_NSRC 24

`endif

/* File: hdl/pirq_iack.v */
// Purpose: VME interrupt handler sequencer: bus request, acknowledge, vector capture
// Assumes: bus grant and acknowledge answers come from logic on the same clock
// Notes: highest pending level wins; one acknowledge in flight at a time
`timescale 1ns/100ps
`default_nettype none

module pirq_iack #(
	parameter VEC_W = 8
) (
	input wire i_clk_sys,
	input wire i_nrst,
	input wire [7:1] i_pend,
	input wire i_vme_bus_grant,
	input wire i_iack_done,
	input wire i_iack_berr,
	input wire [VEC_W-1:0] i_iack_vector,
	output wire o_vme_bus_req,
	output wire o_iack_req,
	output wire [2:0] o_iack_level,
	output reg o_cap_valid,
	output reg [2:0] o_cap_level,
	output reg [VEC_W-1:0] o_cap_vector
);

	localparam ST_IDLE = 2'd0;
	localparam ST_BREQ = 2'd1;
	localparam ST_ACK = 2'd2;
	localparam ST_FIN = 2'd3;

	reg [1:0] st_q;
	reg [1:0] st_d;
	reg [2:0] lvl_q;
	reg [2:0] top_lvl;
	integer i;

	// Highest pending level, 7 beats 1
	always @* begin
		top_lvl = 3'd0;
		for (i = 1; i < 8; i = i + 1) begin
			if (i_pend[i])
				top_lvl = i[2:0];
		end
	end

	// Next state
	always @* begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (|i_pend)
					st_d = ST_BREQ;
			end
			ST_BREQ: begin
				if (i_vme_bus_grant)
					st_d = ST_ACK;
			end
			ST_ACK: begin
				if (i_iack_done || i_iack_berr)
					st_d = ST_FIN;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// hold the bus, then acknowledge the same level
	assign o_vme_bus_req = (st_q == ST_BREQ) || (st_q == ST_ACK);
	assign o_iack_req = (st_q == ST_ACK);
	assign o_iack_level = lvl_q;

	// Level latch and vector capture; FIN lets status settle before rescan
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= ST_IDLE;
			lvl_q <= 3'd0;
			o_cap_valid <= 1'b0;
			o_cap_level <= 3'd0;
			o_cap_vector <= {VEC_W{1'b0}};
		end else begin
			st_q <= st_d;
			o_cap_valid <= 1'b0;
			if (st_q == ST_IDLE && (|i_pend))
				lvl_q <= top_lvl;
			// vector taken only on a clean acknowledge end
			if (st_q == ST_ACK && i_iack_done && !i_iack_berr) begin
				o_cap_valid <= 1'b1;
				o_cap_level <= lvl_q;
				o_cap_vector <= i_iack_vector;
			end
		end
	end

endmodule // pirq_iack

`default_nettype wire

/* File: test/pirq_checker.sv */
// Purpose: port-level checks of the PCI-side interrupt block
// Assumes: one clock domain, reset active low
// Notes: bound to every pirq_top instance
`timescale 1ns/100ps
`default_nettype none
module pirq_checker (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [11:0] i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic [7:1] i_vme_irq_level_line_n,
	input wire logic i_vme_bus_grant,
	input wire logic i_iack_done,
	input wire logic i_iack_berr,
	input wire logic o_vme_bus_req,
	input wire logic o_iack_req,
	input wire logic [2:0] o_iack_level,
	input wire logic [7:0] o_pci_irq_out,
	input wire logic o_irq
);
	// ----
	// Checks
	// ----
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// Steps of a bus access and of an acknowledge
	sequence s_take; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
	sequence s_two; o_iack_req ##1 o_iack_req; endsequence
	sequence s_cap; o_iack_req && i_iack_done; endsequence
	chk_ack_next_cycle: assert property (s_take |=> o_wb_ack)
		else $error("ack late");
	chk_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held");
	chk_rsvd_read_zero: assert property (
		o_wb_ack && !i_wb_we && i_wb_adr == 12'h300 |-> o_wb_dat[31:24] == 8'h00 && !o_wb_dat[11])
		else $error("reserved enable bits set");
	chk_req_until_end: assert property (
		o_vme_bus_req && !i_iack_done && !i_iack_berr |=> o_vme_bus_req)
		else $error("bus request dropped");
	chk_iack_on_grant: assert property (
		o_vme_bus_req && i_vme_bus_grant && !o_iack_req |=> o_iack_req)
		else $error("no acknowledge after grant");
	chk_iack_owns_bus: assert property (o_iack_req |-> o_vme_bus_req)
		else $error("acknowledge without bus");
	chk_level_held: assert property (s_two |-> $stable(o_iack_level))
		else $error("level moved");
	chk_level_line_low: assert property (o_iack_req |-> !i_vme_irq_level_line_n[o_iack_level])
		else $error("acknowledge of idle line");
	chk_irq_after_cap: assert property (s_cap |-> ##3 o_irq)
		else $error("no interrupt after capture");
	chk_irq_or_outs: assert property (o_irq == (|o_pci_irq_out))
		else $error("summary and routed outputs differ");
	chk_req_gap: assert property ($fell(o_vme_bus_req) |=> !o_vme_bus_req)
		else $error("no idle between sequences");
endmodule // pirq_checker
bind pirq_top pirq_checker u_chk (.i_clk_sys, .i_nrst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat,
	.o_wb_ack, .i_vme_irq_level_line_n, .i_vme_bus_grant, .i_iack_done, .i_iack_berr, .o_vme_bus_req,
	.o_iack_req, .o_iack_level, .o_pci_irq_out, .o_irq);
`default_nettype wire

/* File: test/pirq_vme_model.sv */
// Purpose: VME arbiter and interrupter answering acknowledge cycles
// Assumes: same clock as the block
// Notes: delay and bus error chosen by the bench
`timescale 1ns/100ps
`default_nettype none
module pirq_vme_model (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_bus_req,
	input wire logic i_iack_req,
	input wire logic [2:0] i_level,
	input wire logic [3:0] i_delay,
	input wire logic i_berr_mode,
	output logic o_grant,
	output logic o_done,
	output logic o_berr,
	output logic [7:0] o_vector
);
	logic [3:0] wait_q;
	// ----
	// Answer
	// ----
	// Grant follows request; answer after a chosen delay
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_grant <= 1'h0;
			o_done <= 1'h0;
			o_berr <= 1'h0;
			o_vector <= 8'h00;
			wait_q <= 4'h0;
		end else begin
			o_grant <= i_bus_req;
			o_done <= 1'h0;
			o_berr <= 1'h0;
			o_vector <= ~o_vector; // Stale data inverts each cycle, so it repeats the last answer every other cycle
			if (i_iack_req && !o_done && !o_berr) begin
				wait_q <= wait_q + 4'h1;
				if (wait_q >= i_delay) begin
					wait_q <= 4'h0;
					o_done <= !i_berr_mode;
					o_berr <= i_berr_mode;
					o_vector <= {5'h15, i_level};
				end
			end
		end
	end
endmodule // pirq_vme_model
`default_nettype wire

/* File: test/pci_side_irq_enable_vme_handler_tb_top.sv */
// Purpose: self-checking bench of the PCI-side interrupt block
// Assumes: 100 MHz clock, reset held four cycles
// Notes: expectations come from the bit layout, never from the design
`timescale 1ns/100ps
`default_nettype none
`include "pirq_regs.vh"
module pci_side_irq_enable_vme_handler_tb_top;
	logic clk = 1'h0, nrst = 1'h0, cyc = 1'h0, we = 1'h0, acf_n = 1'h1, sysf_n = 1'h1, berr_m = 1'h0;
	logic [11:0] adr = 12'h000;
	logic [3:0] sel = 4'h0, dly = 4'h0;
	logic [31:0] wdat = 32'h0, r, en, w, mp [0:2];
	logic [23:0] ev = 24'h0, evx;
	logic [7:1] line_n = 7'h7f;
	wire ack, breq, ireq, gnt, done, berr, irq;
	wire [31:0] odat;
	wire [2:0] lvl;
	wire [7:0] vec, pout;
	integer miscompares = 0, comparisons = 0, seed = 32'h19d6e756, ndone = 0, cycles = 0, i, k, nb;
	pirq_top u_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(odat), .o_wb_ack(ack),
		.i_loc_watch(ev[23:20]), .i_msgbox(ev[19:16]), .i_soft_vme_ack_irq(ev[12]), .i_vme_err_irq(ev[10]),
		.i_pci_err_irq(ev[9]), .i_dma_irq(ev[8]), .i_vme_own_irq(ev[0]), .i_acfail_n(acf_n),
		.i_sysfail_n(sysf_n), .i_vme_irq_level_line_n(line_n), .i_vme_bus_grant(gnt), .i_iack_done(done),
		.i_iack_berr(berr), .i_iack_vector(vec), .o_vme_bus_req(breq), .o_iack_req(ireq),
		.o_iack_level(lvl), .o_pci_irq_out(pout), .o_irq(irq));
	pirq_vme_model u_vme (.i_clk_sys(clk), .i_nrst(nrst), .i_bus_req(breq), .i_iack_req(ireq),
		.i_level(lvl), .i_delay(dly), .i_berr_mode(berr_m), .o_grant(gnt), .o_done(done), .o_berr(berr),
		.o_vector(vec));
	// ----
	// Helpers
	// ----
	always #5 clk = ~clk;
	// Answers seen and hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (done || berr) ndone <= ndone + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			final_report;
		end
	end
	task final_report;
		if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Classic cycle held until ack is sampled
	task wb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'h1;
		we <= wr;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		for (k = 0; k < 50 && ack !== 1'h1; k++) @(posedge clk);
		r = odat;
		cyc <= 1'h0;
		if (k == 50) miscompares = miscompares + 1;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		wb(1'h0, a, 32'h0);
		chk(r, e);
	endtask
	task wait_n(input integer n);
		for (int t = 0; t < 300 && ndone < n; t++) @(posedge clk);
		chk(ndone, n);
	endtask
	// Expected routed outputs of a status word
	function automatic logic [7:0] route(input logic [23:0] s);
		logic [95:0] m;
		m = {mp[2], mp[1], mp[0]};
		route = 8'h00;
		for (int j = 0; j < 24; j++) if (s[j]) route[m[4*j+:3]] = 1'h1;
	endfunction
	// ----
	// Main sequence
	// ----
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'h1;
		rd(`PIRQ_OFF_EN, 32'h0);
		rd(`PIRQ_OFF_STAT, 32'h0);
		rd(12'hffc, 32'h0);
		wb(1'h1, `PIRQ_OFF_EN, 32'hffffffff);
		rd(`PIRQ_OFF_EN, 32'h00fff7ff);
		rd(`PIRQ_OFF_STAT, 32'h2000);
		wb(1'h1, `PIRQ_OFF_STAT, 32'hffffffff);
		for (i = 0; i < 3; i++) begin
			mp[i] = $random(seed) & 32'h77777777;
			wb(1'h1, 12'(`PIRQ_OFF_MAP0 + 4 * i), mp[i]);
		end
		// Random events, enables, partial clears
		for (i = 0; i < 60; i++) begin
			en = $random(seed) & 32'h00ff1701;
			wb(1'h1, `PIRQ_OFF_EN, en);
			evx = $random(seed) & 24'hff1701;
			ev <= evx;
			@(posedge clk);
			ev <= 24'h0;
			rd(`PIRQ_OFF_STAT, en & evx);
			chk(32'(pout), 32'(route(en & evx)));
			w = $random(seed);
			wb(1'h1, `PIRQ_OFF_STAT, w);
			rd(`PIRQ_OFF_STAT, en & evx & ~w);
			wb(1'h1, `PIRQ_OFF_STAT, 32'hffffffff);
		end
		// Software interrupt edge
		wb(1'h1, `PIRQ_OFF_EN, 32'h0);
		wb(1'h1, `PIRQ_OFF_EN, 32'h2000);
		rd(`PIRQ_OFF_STAT, 32'h2000);
		wb(1'h1, `PIRQ_OFF_STAT, 32'h2000);
		wb(1'h1, `PIRQ_OFF_EN, 32'h2000);
		rd(`PIRQ_OFF_STAT, 32'h0);
		wb(1'h1, `PIRQ_OFF_EN, 32'h0);
		wb(1'h1, `PIRQ_OFF_EN, 32'h2000);
		wb(1'h1, `PIRQ_OFF_EN, 32'h0);
		rd(`PIRQ_OFF_STAT, 32'h2000);
		chk(32'(irq), 32'h0);
		wb(1'h1, `PIRQ_OFF_STAT, 32'h2000);
		// Failure lines follow their pins
		wb(1'h1, `PIRQ_OFF_EN, 32'hc000);
		acf_n <= 1'h0;
		sysf_n <= 1'h0;
		repeat (5) @(posedge clk);
		wb(1'h1, `PIRQ_OFF_STAT, 32'hc000);
		rd(`PIRQ_OFF_STAT, 32'hc000);
		acf_n <= 1'h1;
		sysf_n <= 1'h1;
		repeat (5) @(posedge clk);
		wb(1'h1, `PIRQ_OFF_STAT, 32'hc000);
		rd(`PIRQ_OFF_STAT, 32'h0);
		// Disabled levels ignored, then each level acknowledged
		wb(1'h1, `PIRQ_OFF_EN, 32'h0);
		line_n <= 7'h00;
		repeat (20) @(posedge clk);
		chk(ndone, 0);
		for (i = 1; i < 8; i++) begin
			dly <= 4'($random(seed));
			berr_m <= (i == 4);
			nb = ndone;
			wb(1'h1, `PIRQ_OFF_EN, 32'h1 << i);
			wb(1'h1, `PIRQ_OFF_STAT, 32'hffffffff);
			w = ndone - nb + 32'(i == 4);
			wait_n(nb + 1);
			berr_m <= 1'h0;
			wait_n(nb + w + 1);
			repeat (4) @(posedge clk);
			rd(12'(`PIRQ_OFF_VEC1 + 4 * (i - 1)), {24'h0, 5'h15, 3'(i)});
			rd(`PIRQ_OFF_STAT, 32'h1 << i);
			chk(32'(pout), 32'(route(24'h1 << i)));
			repeat (30) @(posedge clk);
			chk(ndone, nb + w + 1);
			wb(1'h1, `PIRQ_OFF_STAT, 32'h1 << i);
			wait_n(nb + w + 2);
			repeat (4) @(posedge clk);
		end
		final_report;
	end
endmodule // pci_side_irq_enable_vme_handler_tb_top
`default_nettype wire
